// *** core/matrix_status_pkg.sv ***
// constants and carrier types for the matrix switch status bank
package matrix_status_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_MATRIX_LOW = 6'h08;
  localparam logic [5:0] IDX_MATRIX_HIGH = 6'h09;
  localparam logic [5:0] IDX_CONTROL = 6'h10;
  localparam logic [5:0] IDX_MATRIX_THR = 6'h11;
  localparam logic [5:0] IDX_SHARED_THR = 6'h12;
  localparam logic [5:0] IDX_CYCLE_COUNT = 6'h13;

  // field positions and sizes
  localparam int REG_W = 24;
  localparam int LEVEL_W = 10;
  localparam int DRIVES = 6;
  localparam int SENSES = 6;
  localparam int MAT_BITS = 36;
  localparam int MAT_LOW_BITS = 24;
  localparam int MAT_HIGH_BITS = 12;
  localparam int COM_INPUTS = 12;
  localparam int COM_LSB = 12;
  localparam int CTRL_MATRIX_BIT = 0;
  localparam int CTRL_COMMON_BIT = 1;
  localparam int COUNT_W = 16;
  localparam logic [3:0] SENSE_FIRST = 4'ha;
  localparam logic [3:0] SENSE_LAST = 4'hf;
  localparam logic [3:0] DRIVE_FIRST = 4'h4;
  localparam logic [3:0] DRIVE_LAST = 4'h9;

  // values after reset
  localparam logic [REG_W-1:0] STATUS_RESET = 24'h000000;
  localparam logic [LEVEL_W-1:0] THR_RESET = 10'h200;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

  // one comparison result from the polling sequencer
  typedef struct packed {
    logic valid;
    logic common;
    logic [3:0] sense;
    logic [3:0] drive;
    logic [LEVEL_W-1:0] level;
  } poll_sample_t;

  // merged results of the current polling cycle
  typedef struct packed {
    logic [MAT_BITS-1:0] mat_val;
    logic [MAT_BITS-1:0] mat_hit;
    logic [COM_INPUTS-1:0] com_val;
    logic [COM_INPUTS-1:0] com_hit;
  } poll_result_t;

endpackage

// *** core/poll_capture.sv ***
// collects comparison results of one polling cycle
`timescale 1ns/1ns
module poll_capture (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sequencer side
  input wire matrix_status_pkg::poll_sample_t sample,
  input wire logic cycle_end,
  // thresholds
  input wire logic [matrix_status_pkg::LEVEL_W-1:0] matrix_threshold,
  input wire logic [matrix_status_pkg::LEVEL_W-1:0] shared_threshold,
  // merged result including this cycle's sample
  output matrix_status_pkg::poll_result_t result_now
);

  logic [matrix_status_pkg::MAT_BITS-1:0] mat_val_r;
  logic [matrix_status_pkg::MAT_BITS-1:0] mat_hit_r;
  logic [matrix_status_pkg::COM_INPUTS-1:0] com_val_r;
  logic [matrix_status_pkg::COM_INPUTS-1:0] com_hit_r;
  logic mat_ok;
  logic com_ok;
  logic [5:0] mat_idx;
  logic mat_above;
  logic com_above;

  // sense-major, drive-minor position of a pairing
  function automatic logic [5:0] pair_index(input logic [3:0] sense, input logic [3:0] drive);
    logic [5:0] s;
    logic [5:0] d;
    s = {2'h0, sense - matrix_status_pkg::SENSE_FIRST};
    d = {2'h0, drive - matrix_status_pkg::DRIVE_FIRST};
    pair_index = 6'(s * 6'(matrix_status_pkg::DRIVES) + d);
  endfunction

  assign mat_ok = sample.valid && !sample.common &&
                  sample.sense >= matrix_status_pkg::SENSE_FIRST && sample.sense <= matrix_status_pkg::SENSE_LAST &&
                  sample.drive >= matrix_status_pkg::DRIVE_FIRST && sample.drive <= matrix_status_pkg::DRIVE_LAST;
  assign com_ok = sample.valid && sample.common && sample.sense < 4'(matrix_status_pkg::COM_INPUTS);
  assign mat_idx = pair_index(sample.sense, sample.drive);
  // matrix bit set only strictly above
  assign mat_above = sample.level > matrix_threshold;
  // common bit set at or above
  assign com_above = sample.level >= shared_threshold;

  always_comb begin
    result_now.mat_val = mat_val_r;
    result_now.mat_hit = mat_hit_r;
    result_now.com_val = com_val_r;
    result_now.com_hit = com_hit_r;
    if (mat_ok) begin
      result_now.mat_val[mat_idx] = mat_above;
      result_now.mat_hit[mat_idx] = 1'b1;
    end
    if (com_ok) begin
      result_now.com_val[sample.sense] = com_above;
      result_now.com_hit[sample.sense] = 1'b1;
    end
  end

  // values are kept; hit marks restart each cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mat_val_r <= '0;
      com_val_r <= '0;
    end else begin
      mat_val_r <= result_now.mat_val;
      com_val_r <= result_now.com_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mat_hit_r <= '0;
      com_hit_r <= '0;
    end else if (cycle_end) begin
      mat_hit_r <= '0;
      com_hit_r <= '0;
    end else begin
      mat_hit_r <= result_now.mat_hit;
      com_hit_r <= result_now.com_hit;
    end
  end

  mat_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    mat_ok && sample.sense == 4'ha && sample.drive == 4'h4 |=> mat_val_r[0] == $past(mat_above))
    else $error("sense 10 drive 4 not in bit 0");

  mat_last_a: assert property (@(posedge pclk) disable iff (!presetn)
    mat_ok && sample.sense == 4'hf && sample.drive == 4'h9 |=> mat_val_r[35] == $past(mat_above))
    else $error("sense 15 drive 9 not in top matrix bit");

  mat_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    mat_ok && sample.level == matrix_threshold |=> !mat_val_r[$past(mat_idx)])
    else $error("matrix bit set at equal level");

  com_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    com_ok && sample.level == shared_threshold |=> com_val_r[$past(sample.sense)])
    else $error("common bit clear at equal level");

endmodule

// *** core/matrix_switch_status_regs.sv ***
// apb register bank holding matrix and shared-threshold status
//
// Summary of operation
// - matrix mode sets bits for sense 10-15 x drive 4-9
// - matrix bit one when above threshold, else zero
// - low register sense-major, bit 0 is 10/4
// - high register bits 11..0 hold sense 14, 15
// - high bit 11 is 15/9, bit 0 is 14/4
// - high bits 12..23 hold inputs 0..11 common
// - common bit one when equal or above threshold
// - status fields read only, reset to zero
`timescale 1ns/1ns
module matrix_switch_status_regs #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // polling sequencer
  input wire matrix_status_pkg::poll_sample_t poll_sample,
  input wire logic poll_cycle_end,
  // status copies for neighbouring logic
  output logic [matrix_status_pkg::REG_W-1:0] matrix_status_low,
  output logic [matrix_status_pkg::REG_W-1:0] matrix_status_high_common
);

  logic [matrix_status_pkg::REG_W-1:0] matrix_status_low_r;
  logic [matrix_status_pkg::REG_W-1:0] matrix_status_low_nxt;
  logic [matrix_status_pkg::REG_W-1:0] matrix_status_high_common_r;
  logic [matrix_status_pkg::REG_W-1:0] matrix_status_high_common_nxt;
  logic [1:0] control_r;
  logic [matrix_status_pkg::LEVEL_W-1:0] matrix_threshold_r;
  logic [matrix_status_pkg::LEVEL_W-1:0] shared_threshold_r;
  logic [matrix_status_pkg::COUNT_W-1:0] cycle_count_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pslverr_r;
  logic pslverr_nxt;
  logic setup;
  logic access;
  logic wr_take;
  logic matrix_en;
  logic common_en;
  logic committed_r;
  logic [matrix_status_pkg::MAT_BITS-1:0] mat_merged;
  logic [matrix_status_pkg::COM_INPUTS-1:0] com_merged;
  matrix_status_pkg::poll_result_t result_now;

  // decode shared by read and write paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] index);
    reg_hit = addr[1:0] == 2'h0 && addr[ADDR_W-1:2] == (ADDR_W-2)'(index);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    mapped = reg_hit(addr, matrix_status_pkg::IDX_MATRIX_LOW) ||
             reg_hit(addr, matrix_status_pkg::IDX_MATRIX_HIGH) ||
             reg_hit(addr, matrix_status_pkg::IDX_CONTROL) ||
             reg_hit(addr, matrix_status_pkg::IDX_MATRIX_THR) ||
             reg_hit(addr, matrix_status_pkg::IDX_SHARED_THR) ||
             reg_hit(addr, matrix_status_pkg::IDX_CYCLE_COUNT);
  endfunction

  poll_capture capture (
    .pclk(pclk),
    .presetn(presetn),
    .sample(poll_sample),
    .cycle_end(poll_cycle_end),
    .matrix_threshold(matrix_threshold_r),
    .shared_threshold(shared_threshold_r),
    .result_now(result_now)
  );

  assign setup = psel && !penable;
  assign access = psel && penable && pready_r;
  assign wr_take = access && pwrite;
  assign matrix_en = control_r[matrix_status_pkg::CTRL_MATRIX_BIT];
  assign common_en = control_r[matrix_status_pkg::CTRL_COMMON_BIT];

  // sampled pairings take the new result, others keep theirs
  assign mat_merged = (result_now.mat_val & result_now.mat_hit) |
                      ({matrix_status_high_common_r[11:0], matrix_status_low_r} & ~result_now.mat_hit);
  assign com_merged = (result_now.com_val & result_now.com_hit) |
                      (matrix_status_high_common_r[23:12] & ~result_now.com_hit);

  always_comb begin
    matrix_status_low_nxt = matrix_status_low_r;
    matrix_status_high_common_nxt = matrix_status_high_common_r;
    if (poll_cycle_end && matrix_en) begin
      matrix_status_low_nxt = mat_merged[23:0];
      matrix_status_high_common_nxt[11:0] = mat_merged[35:24];
    end
    if (poll_cycle_end && common_en) begin
      matrix_status_high_common_nxt[23:12] = com_merged;
    end
  end

  // status only ever follows the poller, never the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      matrix_status_low_r <= matrix_status_pkg::STATUS_RESET;
      matrix_status_high_common_r <= matrix_status_pkg::STATUS_RESET;
    end else begin
      matrix_status_low_r <= matrix_status_low_nxt;
      matrix_status_high_common_r <= matrix_status_high_common_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      matrix_status_low <= matrix_status_pkg::STATUS_RESET;
      matrix_status_high_common <= matrix_status_pkg::STATUS_RESET;
    end else begin
      matrix_status_low <= matrix_status_low_nxt;
      matrix_status_high_common <= matrix_status_high_common_nxt;
    end
  end

  // polling cycle counter, wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_count_r <= matrix_status_pkg::COUNT_RESET;
    end else if (poll_cycle_end) begin
      cycle_count_r <= cycle_count_r + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      committed_r <= 1'b0;
    end else if (poll_cycle_end) begin
      committed_r <= 1'b1;
    end
  end

  // writable control and thresholds, low byte lanes honoured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_r <= matrix_status_pkg::CTRL_RESET;
    end else if (wr_take && reg_hit(paddr, matrix_status_pkg::IDX_CONTROL) && pstrb[0]) begin
      control_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      matrix_threshold_r <= matrix_status_pkg::THR_RESET;
    end else if (wr_take && reg_hit(paddr, matrix_status_pkg::IDX_MATRIX_THR)) begin
      if (pstrb[0]) begin
        matrix_threshold_r[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        matrix_threshold_r[9:8] <= pwdata[9:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_threshold_r <= matrix_status_pkg::THR_RESET;
    end else if (wr_take && reg_hit(paddr, matrix_status_pkg::IDX_SHARED_THR)) begin
      if (pstrb[0]) begin
        shared_threshold_r[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        shared_threshold_r[9:8] <= pwdata[9:8];
      end
    end
  end

  // read data and error prepared during setup
  always_comb begin
    prdata_nxt = 32'h00000000;
    pslverr_nxt = !mapped(paddr);
    if (!pwrite) begin
      if (reg_hit(paddr, matrix_status_pkg::IDX_MATRIX_LOW)) begin
        prdata_nxt = {8'h00, matrix_status_low_r};
      end else if (reg_hit(paddr, matrix_status_pkg::IDX_MATRIX_HIGH)) begin
        prdata_nxt = {8'h00, matrix_status_high_common_r};
      end else if (reg_hit(paddr, matrix_status_pkg::IDX_CONTROL)) begin
        prdata_nxt = {30'h0, control_r};
      end else if (reg_hit(paddr, matrix_status_pkg::IDX_MATRIX_THR)) begin
        prdata_nxt = {22'h0, matrix_threshold_r};
      end else if (reg_hit(paddr, matrix_status_pkg::IDX_SHARED_THR)) begin
        prdata_nxt = {22'h0, shared_threshold_r};
      end else if (reg_hit(paddr, matrix_status_pkg::IDX_CYCLE_COUNT)) begin
        prdata_nxt = {16'h0000, cycle_count_r};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end else if (access) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ready_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready)
    else $error("access phase not answered in one cycle");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !mapped(paddr) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped address not flagged");

  status_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && !poll_cycle_end |=> $stable(matrix_status_low_r) && $stable(matrix_status_high_common_r))
    else $error("bus write altered status");

  reset_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !committed_r |-> matrix_status_low_r == 24'h000000 && matrix_status_high_common_r == 24'h000000)
    else $error("status not zero before first poll cycle");

  hold_between_a: assert property (@(posedge pclk) disable iff (!presetn)
    !poll_cycle_end |=> $stable(matrix_status_low_r) && $stable(matrix_status_high_common_r))
    else $error("status changed outside cycle end");

  low_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    poll_cycle_end && matrix_en && result_now.mat_hit[0] |=> matrix_status_low_r[0] == $past(result_now.mat_val[0]))
    else $error("sense 10 drive 4 not committed");

  high_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    poll_cycle_end && matrix_en && result_now.mat_hit[24] |=>
      matrix_status_high_common_r[0] == $past(result_now.mat_val[24]))
    else $error("sense 14 drive 4 not in high bit 0");

  com_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    poll_cycle_end && common_en && result_now.com_hit[0] |=>
      matrix_status_high_common_r[12] == $past(result_now.com_val[0]))
    else $error("input 0 common result not in bit 12");

  read_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && reg_hit(paddr, matrix_status_pkg::IDX_MATRIX_LOW) && !poll_cycle_end |=>
      prdata == {8'h00, matrix_status_low_r})
    else $error("low register read mismatch");

  mode_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !matrix_en |=> $stable(matrix_status_low_r))
    else $error("matrix bits changed outside matrix mode");

  low_last_a: assert property (@(posedge pclk) disable iff (!presetn)
    poll_cycle_end && matrix_en && result_now.mat_hit[23] |=>
      matrix_status_low_r[23] == $past(result_now.mat_val[23]))
    else $error("sense 13 drive 9 not in bit 23");

  high_last_a: assert property (@(posedge pclk) disable iff (!presetn)
    poll_cycle_end && matrix_en && result_now.mat_hit[35] |=>
      matrix_status_high_common_r[11] == $past(result_now.mat_val[35]))
    else $error("sense 15 drive 9 not in high bit 11");

  com_last_a: assert property (@(posedge pclk) disable iff (!presetn)
    poll_cycle_end && common_en && result_now.com_hit[11] |=>
      matrix_status_high_common_r[23] == $past(result_now.com_val[11]))
    else $error("input 11 common result not in bit 23");

  com_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !common_en |=> $stable(matrix_status_high_common_r[23:12]))
    else $error("common bits changed with common mode off");

  high_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !matrix_en |=> $stable(matrix_status_high_common_r[11:0]))
    else $error("high matrix bits changed outside matrix mode");

  mat_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    poll_cycle_end && matrix_en && !result_now.mat_hit[0] |=> $stable(matrix_status_low_r[0]))
    else $error("unsampled matrix pairing changed");

  com_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    poll_cycle_end && common_en && !result_now.com_hit[0] |=> $stable(matrix_status_high_common_r[12]))
    else $error("unsampled common input changed");

  port_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    matrix_status_low == matrix_status_low_r && matrix_status_high_common == matrix_status_high_common_r)
    else $error("status copy differs from register");

  read_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && reg_hit(paddr, matrix_status_pkg::IDX_MATRIX_HIGH) && !poll_cycle_end |=>
      prdata == {8'h00, matrix_status_high_common_r})
    else $error("high register read mismatch");

  idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> !pready && !pslverr && prdata == 32'h00000000)
    else $error("bus answer outside a transfer");

endmodule

// *** verification/test_matrix_switch_status_regs.sv ***
// self-checking testbench for the matrix switch status register bank
`timescale 1ns/1ns
module test_matrix_switch_status_regs;
  localparam logic [7:0] A_LOW = {matrix_status_pkg::IDX_MATRIX_LOW, 2'b00};
  localparam logic [7:0] A_HIGH = {matrix_status_pkg::IDX_MATRIX_HIGH, 2'b00};
  localparam logic [7:0] A_CTRL = {matrix_status_pkg::IDX_CONTROL, 2'b00};
  localparam logic [7:0] A_MTHR = {matrix_status_pkg::IDX_MATRIX_THR, 2'b00};
  localparam logic [7:0] A_STHR = {matrix_status_pkg::IDX_SHARED_THR, 2'b00};
  localparam logic [7:0] A_CNT = {matrix_status_pkg::IDX_CYCLE_COUNT, 2'b00};

  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  matrix_status_pkg::poll_sample_t poll_sample;
  logic poll_cycle_end;
  logic [23:0] matrix_status_low;
  logic [23:0] matrix_status_high_common;
  logic [35:0] exp_mat;
  logic [11:0] exp_com;
  logic [31:0] rd;
  logic er;
  int errors;
  int n_compared;
  int commits;

  matrix_switch_status_regs #(.ADDR_W(8)) i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .poll_sample(poll_sample),
    .poll_cycle_end(poll_cycle_end),
    .matrix_status_low(matrix_status_low),
    .matrix_status_high_common(matrix_status_high_common)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h00000000);
    chk(nm, e, rd);
    chk({nm, "_err"}, {31'h0, ee}, {31'h0, er});
  endtask

  task smp(input logic c, input logic [3:0] s, input logic [3:0] d, input logic [9:0] l);
    poll_sample <= '{1'b1, c, s, d, l};
    @(posedge pclk);
  endtask

  task commit;
    poll_sample <= '0;
    poll_cycle_end <= 1'b1;
    @(posedge pclk);
    poll_cycle_end <= 1'b0;
    commits++;
    @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    poll_sample = '0;
    poll_cycle_end = 1'b0;
    errors = 0;
    n_compared = 0;
    commits = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values
    rdchk("low_reset", A_LOW, 32'h00000000, 1'b0);
    rdchk("high_reset", A_HIGH, 32'h00000000, 1'b0);
    rdchk("ctrl_reset", A_CTRL, {30'h0, matrix_status_pkg::CTRL_RESET}, 1'b0);
    rdchk("mthr_reset", A_MTHR, {22'h0, matrix_status_pkg::THR_RESET}, 1'b0);
    rdchk("sthr_reset", A_STHR, {22'h0, matrix_status_pkg::THR_RESET}, 1'b0);
    $display("test reset_values done");
    // full sweep, equal levels at the boundary
    apb(1'b1, A_MTHR, 32'h00000155);
    apb(1'b1, A_STHR, 32'h000000aa);
    rdchk("mthr", A_MTHR, 32'h00000155, 1'b0);
    for (int s = 0; s < 6; s++) begin
      for (int d = 0; d < 6; d++) begin
        exp_mat[s * 6 + d] = ((s * 6 + d) % 7 < 3);
        smp(1'b0, 4'ha + s[3:0], 4'h4 + d[3:0], ((s * 6 + d) % 7 < 3) ? 10'h156 : 10'h155);
      end
    end
    for (int i = 0; i < 12; i++) begin
      exp_com[i] = (i % 5 != 2);
      smp(1'b1, i[3:0], 4'h0, (i % 5 != 2) ? 10'h0aa : 10'h0a9);
    end
    commit();
    chk("low_port", {8'h0, exp_mat[23:0]}, {8'h0, matrix_status_low});
    rdchk("low_sweep", A_LOW, {8'h0, exp_mat[23:0]}, 1'b0);
    rdchk("high_sweep", A_HIGH, {8'h0, exp_com, exp_mat[35:24]}, 1'b0);
    $display("test sweep done");
    // partial refresh, later sample of a pairing wins
    smp(1'b0, 4'ha, 4'h4, 10'h3ff);
    smp(1'b0, 4'ha, 4'h4, 10'h000);
    smp(1'b1, 4'h0, 4'h0, 10'h000);
    commit();
    exp_mat[0] = 1'b0;
    exp_com[0] = 1'b0;
    rdchk("low_refresh", A_LOW, {8'h0, exp_mat[23:0]}, 1'b0);
    rdchk("high_refresh", A_HIGH, {8'h0, exp_com, exp_mat[35:24]}, 1'b0);
    chk("high_port", {8'h0, exp_com, exp_mat[35:24]}, {8'h0, matrix_status_high_common});
    $display("test refresh done");
    // both modes off: nothing committed
    apb(1'b1, A_CTRL, 32'h00000000);
    smp(1'b0, 4'hf, 4'h9, 10'h000);
    smp(1'b1, 4'hb, 4'h0, 10'h000);
    commit();
    rdchk("high_disabled", A_HIGH, {8'h0, exp_com, exp_mat[35:24]}, 1'b0);
    // matrix mode alone
    apb(1'b1, A_CTRL, 32'h00000001);
    smp(1'b0, 4'hf, 4'h9, 10'h000);
    smp(1'b1, 4'hb, 4'h0, 10'h000);
    commit();
    exp_mat[35] = 1'b0;
    rdchk("high_matrix_only", A_HIGH, {8'h0, exp_com, exp_mat[35:24]}, 1'b0);
    // common mode alone
    apb(1'b1, A_CTRL, 32'h00000002);
    smp(1'b0, 4'ha, 4'h7, 10'h3ff);
    smp(1'b1, 4'hb, 4'h0, 10'h000);
    commit();
    exp_com[11] = 1'b0;
    rdchk("low_common_only", A_LOW, {8'h0, exp_mat[23:0]}, 1'b0);
    rdchk("high_common_only", A_HIGH, {8'h0, exp_com, exp_mat[35:24]}, 1'b0);
    apb(1'b1, A_CTRL, 32'h00000003);
    rdchk("count", A_CNT, commits, 1'b0);
    $display("test disabled done");
    // writes to read-only and unmapped places
    apb(1'b1, A_LOW, 32'hffffffff);
    chk("low_write_err", 32'h0, {31'h0, er});
    apb(1'b1, A_HIGH, 32'h00000000);
    rdchk("low_ro", A_LOW, {8'h0, exp_mat[23:0]}, 1'b0);
    rdchk("high_ro", A_HIGH, {8'h0, exp_com, exp_mat[35:24]}, 1'b0);
    rdchk("unmapped", 8'h30, 32'h00000000, 1'b1);
    rdchk("unaligned", 8'h21, 32'h00000000, 1'b1);
    apb(1'b1, 8'h30, 32'h12345678);
    chk("unmapped_write_err", 32'h1, {31'h0, er});
    $display("test access done");
    // reset in mid-run clears the status
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("low_port_rst", 32'h0, {8'h0, matrix_status_low});
    rdchk("low_rst", A_LOW, 32'h00000000, 1'b0);
    rdchk("high_rst", A_HIGH, 32'h00000000, 1'b0);
    $display("test mid_reset done");
    stop_test();
  end
endmodule
